/* File: dv/board_model.sv */
// Board model: gated clock pin and resolved macrocell pin levels
`timescale 1ns/1ps
module board_model
   import pld_ctrl_pkg::*;
#(
   parameter int WAIT_CYC = 8                 // Quiet cycles after reset
)(
   input  wire logic                 clk,     // Clock
   input  wire logic                 rst,     // Reset
   input  wire logic                 clk_req, // Bench wants clock high
   input  wire logic [NUM_CELLS-1:0] ext_en,  // Board drives pin
   input  wire logic [NUM_CELLS-1:0] ext_v,   // Board level
   input  wire logic [NUM_CELLS-1:0] io_out,  // Device value
   input  wire logic [NUM_CELLS-1:0] io_oe,   // Device enable
   input  wire logic [NUM_CELLS-1:0] io_keep, // Keeper level
   output logic                      clk_pin, // Clock pin
   output logic [NUM_CELLS-1:0]      io_in    // Pin level
);
   int quiet_q;  // Cycles since reset
   // Count out the reset interval
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         quiet_q <= 0;
      else if (quiet_q < WAIT_CYC)
         quiet_q <= quiet_q + 1;
   end
   // Clock stays still until setup is safe
   assign clk_pin = clk_req && (quiet_q == WAIT_CYC);
   // Device first, then board, else keeper holds
   assign io_in = (io_oe & io_out) | (~io_oe & ext_en & ext_v) | (~io_oe & ~ext_en & io_keep);
endmodule : board_model

/* File: dv/pld_ctrl_bench.sv */
// Testbench: bus-driven checks of preload, sleep, fuse, signature, keepers
`timescale 1ns/1ps
module pld_ctrl_bench
   import pld_ctrl_pkg::*;
;
   localparam int PR = 4;                    // Short power-up interval
   logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
   logic sleep_hold_pin, clk_pin, oe_n_pin, clk_req;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NUM_DIN-1:0] din_pin, din_keep;
   logic [NUM_CELLS-1:0] io_in, io_out, io_oe, io_keep, ext_en, ext_v;
   int err_count = 0, checks_done = 0;
   pld_ctrl #(.PR_CYC(PR)) dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .sleep_hold_pin(sleep_hold_pin), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .din_pin(din_pin),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .io_keep(io_keep), .din_keep(din_keep));
   board_model #(.WAIT_CYC(PR + 2)) board_u (.clk(clk), .rst(rst), .clk_req(clk_req), .ext_en(ext_en),
      .ext_v(ext_v), .io_out(io_out), .io_oe(io_oe), .io_keep(io_keep), .clk_pin(clk_pin), .io_in(io_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   // Bus cycle: setup, access, hold until ready sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         err_count++;
         final_report();
      end
   endtask : apb
   // One clock pin pulse, long enough for the synchroniser
   task automatic pulse();
      @(posedge clk);
      clk_req <= 1'b1;
      repeat (4) @(posedge clk);
      clk_req <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : pulse
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      {sleep_hold_pin, oe_n_pin, din_pin, clk_req, ext_en, ext_v} = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (PR + 2) @(posedge clk);
      apb(0, ADDR_STATUS, 0);
      chk(rd, 32'h00000008);
      apb(0, ADDR_CELLCFG, 0);
      chk(rd, 32'h0000FFFF);
      chk(32'(io_oe), 32'h0);
      apb(0, 8'h40, 0);
      chk(rd | 32'(er), 32'h1);
      ext_en <= 8'h02;
      ext_v <= 8'h02;
      repeat (3) @(posedge clk);
      ext_en <= 8'h00;
      repeat (4) @(posedge clk);
      chk(32'(io_keep & 8'h02), 32'h2);
      apb(1, ADDR_SIG_HI, 32'hA5C30F96);
      apb(0, ADDR_SIG_HI, 0);
      chk(rd, 32'hA5C30F96);
      // Cell 0 registered, term 0 on the first dedicated input
      din_pin <= 7'h01;
      apb(1, ADDR_CELLCFG, 32'h0000FFFC);
      apb(1, ADDR_TIDX, 0);
      apb(1, ADDR_TDATA, 32'h00000002);
      apb(1, ADDR_PRELOAD, 0);
      repeat (4) @(posedge clk);
      chk(32'(io_out & io_oe & 8'h01), 32'h1);
      pulse();
      chk(32'(io_out & 8'h01), 32'h0);
      // Sleep with option on: clock and enable changes ignored
      apb(1, ADDR_PRELOAD, 0);
      apb(1, ADDR_CTRL, 1);
      sleep_hold_pin <= 1'b1;
      repeat (3) @(posedge clk);
      oe_n_pin <= 1'b1;
      pulse();
      chk(32'(io_out & io_oe & 8'h01), 32'h1);
      apb(0, ADDR_STATUS, 0);
      chk(rd, 32'h0000000E);
      sleep_hold_pin <= 1'b0;
      repeat (5) @(posedge clk);
      chk(32'(io_oe & 8'h01), 32'h0);
      apb(0, ADDR_PRELOAD, 0);
      chk(rd & 32'h1, 32'h0);
      pulse();
      apb(0, ADDR_PRELOAD, 0);
      chk(rd & 32'h1, 32'h1);
      // Option off: sleep pin feeds the array
      apb(1, ADDR_CTRL, 0);
      apb(1, ADDR_TDATA, 32'h00000001);
      apb(1, ADDR_PRELOAD, 0);
      sleep_hold_pin <= 1'b1;
      pulse();
      apb(0, ADDR_PRELOAD, 0);
      chk(rd & 32'h1, 32'h1);
      apb(1, ADDR_CELLCFG, 32'h0000FFFD);
      apb(0, ADDR_STATUS, 0);
      chk(rd, 32'h00000009);
      chk(32'(io_oe & ~io_out & 8'h01), 32'h1);
      // Fuse shuts preload, signature stays readable
      apb(1, ADDR_CTRL, 2);
      apb(0, ADDR_PRELOAD, 0);
      chk(rd | 32'(er), 32'h1);
      apb(0, ADDR_SIG_HI, 0);
      chk(rd, 32'hA5C30F96);
      final_report();
   end
endmodule : pld_ctrl_bench

/* File: dv/pld_ctrl_properties.sv */
// Checker: bus, keeper and sleep properties at the block ports
`timescale 1ns/1ps
module pld_ctrl_properties
   import pld_ctrl_pkg::*;
#(
   parameter int PR_CYC = PR_CYCLES          // Power-up interval
)(
   input wire logic                 clk,     // Clock
   input wire logic                 rst,     // Reset
   input wire logic                 psel,    // Select
   input wire logic                 penable, // Access
   input wire logic                 pwrite,  // Direction
   input wire logic [7:0]           paddr,   // Address
   input wire logic [31:0]          pwdata,  // Write data
   input wire logic                 pready,  // Ready
   input wire logic [31:0]          prdata,  // Read data
   input wire logic                 pslverr, // Error
   input wire logic                 sleep_hold_pin, // Sleep pin
   input wire logic [NUM_DIN-1:0]   din_pin, // Inputs
   input wire logic [NUM_CELLS-1:0] io_in,   // Pin level
   input wire logic [NUM_CELLS-1:0] io_out,  // Drive value
   input wire logic [NUM_CELLS-1:0] io_oe,   // Drive enable
   input wire logic [NUM_CELLS-1:0] io_keep, // Keeper
   input wire logic [NUM_DIN-1:0]   din_keep // Keeper
);
   // ---------------------------------------------------------
   // Control bits mirrored from bus writes
   // ---------------------------------------------------------
   logic pd_q;   // Sleep option on
   logic sec_q;  // Fuse set, only reset clears it
   wire  acc = psel && penable;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pd_q  <= 1'b0;
         sec_q <= 1'b0;
      end
      else if (acc && pwrite && paddr == ADDR_CTRL)
      begin
         pd_q  <= pwdata[CTRL_PD_EN_BIT];
         sec_q <= sec_q | pwdata[CTRL_SECURE_BIT];
      end
   end
   // ---------------------------------------------------------
   // Properties
   // ---------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_asleep; sleep_hold_pin [*6]; endsequence
   sequence s_live; !$past(rst, 2) && !$past(rst); endsequence
   property p_ready; acc |-> pready; endproperty
   property p_idle; !acc |-> !pready && !pslverr; endproperty
   property p_unmap; acc && paddr > ADDR_SIG_HI |-> pslverr && (pwrite || prdata == 32'h0); endproperty
   property p_sig; acc && !pwrite && (paddr == ADDR_SIG_LO || paddr == ADDR_SIG_HI) |-> !pslverr; endproperty
   property p_fuse; acc && sec_q && paddr == ADDR_PRELOAD |-> pslverr && (pwrite || prdata == 32'h0); endproperty
   property p_freeze; pd_q ##0 s_asleep |-> $stable(io_out) && $stable(io_oe); endproperty
   property p_keep; s_live |-> io_keep == $past(io_in, 2) && din_keep == $past(din_pin, 2); endproperty
   property p_boot; $fell(rst) |-> io_oe == 8'h00; endproperty
   a_ready: assert property (p_ready) else $error("no ready in access");
   a_idle: assert property (p_idle) else $error("ready or error outside access");
   a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
   a_sig: assert property (p_sig) else $error("signature read refused");
   a_fuse: assert property (p_fuse) else $error("preload open under fuse");
   a_freeze: assert property (p_freeze) else $error("outputs moved asleep");
   a_keep: assert property (p_keep) else $error("keeper lost level");
   a_boot: assert property (p_boot) else $error("pin driven after reset");
endmodule : pld_ctrl_properties

bind pld_ctrl pld_ctrl_properties #(.PR_CYC(PR_CYC)) chk_u (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .sleep_hold_pin(sleep_hold_pin), .din_pin(din_pin), .io_in(io_in), .io_out(io_out),
   .io_oe(io_oe), .io_keep(io_keep), .din_keep(din_keep));

/* File: hdl/pld_ctrl.sv */
// Module: control logic around eight macrocells with sleep, preload, fuse and signature
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
module pld_ctrl
   import pld_ctrl_pkg::*;
#(
   parameter int PR_CYC = PR_CYCLES                      // Power-up interval in cycles
)(
   input  wire logic                 clk,                // System clock
   input  wire logic                 rst,                // Async reset, high
   input  wire logic                 psel,               // APB select
   input  wire logic                 penable,            // APB access phase
   input  wire logic                 pwrite,             // APB direction
   input  wire logic [7:0]           paddr,              // APB byte address
   input  wire logic [31:0]          pwdata,             // APB write data
   output logic                      pready,             // APB ready
   output logic [31:0]               prdata,             // APB read data
   output logic                      pslverr,            // APB error
   input  wire logic                 sleep_hold_pin,     // Sleep control / plain input
   input  wire logic                 clk_pin,            // Common register clock pin
   input  wire logic                 oe_n_pin,           // Common output enable, low
   input  wire logic [NUM_DIN-1:0]   din_pin,            // Dedicated input pins
   input  wire logic [NUM_CELLS-1:0] io_in,              // Macrocell pin level
   output logic [NUM_CELLS-1:0]      io_out,             // Macrocell pin drive value
   output logic [NUM_CELLS-1:0]      io_oe,              // Macrocell pin drive enable
   output logic [NUM_CELLS-1:0]      io_keep,            // Keeper level for each I/O pin
   output logic [NUM_DIN-1:0]        din_keep            // Keeper level for each input pin
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int SYNC_W = 3 + NUM_DIN + NUM_CELLS;      // All pins through one synchroniser

   logic [SYNC_W-1:0]    sync1_q, sync2_q;               // Two-stage pin synchroniser
   logic                 sleep_s, clkp_s, oen_s;         // Synchronised control pins
   logic [NUM_DIN-1:0]   din_s;                          // Synchronised inputs
   logic [NUM_CELLS-1:0] io_s;                           // Synchronised I/O levels
   logic                 clkp_prev_q;                    // Clock pin history
   logic                 pd_en_q, secure_q;              // Control bits
   logic [15:0]          cellcfg_q;                      // Macrocell modes
   logic [TIDX_W-1:0]    tidx_q;                         // Term index
   term_t                terms_q [NUM_TERMS];            // Product-term array
   logic [63:0]          sig_q;                          // User signature
   logic [NUM_CELLS-1:0] mc_q;                           // Macrocell registers
   logic [NUM_DIN-1:0]   din_q;                          // Held dedicated inputs
   logic [NUM_CELLS-1:0] io_q;                           // Held I/O feedback
   logic                 sleep_in_q;                     // Held sleep pin as array input
   logic                 oen_q;                          // Held output enable pin
   logic [15:0]          pr_cnt_q;                       // Power-up interval counter
   logic                 pr_done_q;                      // Interval elapsed
   logic                 asleep;                         // Held state active
   logic                 clk_edge;                       // Accepted clock pin edge
   logic [ARRAY_W-1:0]   arr;                            // Array inputs
   logic [ARRAY_W-1:0]   lit_mask;                       // Columns allowed into terms
   logic [NUM_TERMS-1:0] pt;                             // Product-term results
   logic [NUM_CELLS-1:0] sum_all, sum_seven;             // Sum of 8 or of terms 1..7
   logic [NUM_CELLS-1:0] out_d, oe_d;                    // Next pin drive
   arch_t                arch;                           // Derived architecture
   status_t              status;                         // Status word
   logic                 acc, wr, rd;                    // APB strobes
   logic                 hit, refused;                   // Address decode results
   logic [31:0]          rdata_d;                        // Read mux

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Product term: every selected literal true; an empty term is off
   function automatic logic term_eval(input term_t t, input logic [ARRAY_W-1:0] a,
                                      input logic [ARRAY_W-1:0] m);
      logic [ARRAY_W-1:0] tr, cm;
      tr = t.tru & m;
      cm = t.cmpl & m;
      term_eval = ((tr | cm) != '0) && ((a & tr) == tr) && ((~a & cm) == cm);
   endfunction : term_eval

   function automatic cell_mode_t cell_mode(input logic [15:0] cfg, input int i);
      cell_mode = cell_mode_t'(cfg[2*i +: 2]);
   endfunction : cell_mode

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   // Plain two flops; only the second stage is read below
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= {io_in, din_pin, oe_n_pin, clk_pin, sleep_hold_pin};
         sync2_q <= sync1_q;
      end
   end

   assign sleep_s = sync2_q[0];
   assign clkp_s  = sync2_q[1];
   assign oen_s   = sync2_q[2];
   assign din_s   = sync2_q[3 +: NUM_DIN];
   assign io_s    = sync2_q[3 + NUM_DIN +: NUM_CELLS];

   // Sleep pin only acts as sleep when the option is chosen
   assign asleep  = pd_en_q & sleep_s;

   // Keepers follow the pin level at all times, asleep or not
   assign io_keep  = io_s;
   assign din_keep = din_s;

   // ----------------------------------------------------------------
   // Power-up interval
   // ----------------------------------------------------------------
   // Clock pin edges are not honoured until the interval has run out
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pr_cnt_q  <= '0;
         pr_done_q <= 1'b0;
      end
      else if (!pr_done_q)
      begin
         pr_cnt_q  <= pr_cnt_q + 16'h0001;
         pr_done_q <= (pr_cnt_q == 16'(PR_CYC - 1));
      end
   end

   // ----------------------------------------------------------------
   // Input holding
   // ----------------------------------------------------------------
   // Inputs are latched only while awake, so array stays frozen asleep
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         din_q      <= '0;
         io_q       <= '0;
         sleep_in_q <= 1'b0;
         oen_q      <= 1'b1;
      end
      else if (!asleep)
      begin
         din_q      <= din_s;
         io_q       <= io_s;
         sleep_in_q <= sleep_s;
         oen_q      <= oen_s;
      end
   end

   // History always tracks, so an edge made while asleep is dropped
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         clkp_prev_q <= 1'b0;
      else
         clkp_prev_q <= clkp_s;
   end

   assign clk_edge = clkp_s & ~clkp_prev_q & ~asleep & pr_done_q;

   // ----------------------------------------------------------------
   // Logic array
   // ----------------------------------------------------------------
   // Sleep column is masked out of every term when the option is on
   always_comb
   begin
      lit_mask            = '1;
      lit_mask[SLEEP_LIT] = ~pd_en_q;
   end

   // Combinatorial feedback comes from the pin, registered from the flop
   always_comb
   begin
      arr = {mc_q, din_q, sleep_in_q};
      for (int i = 0; i < NUM_CELLS; i++)
         if (cell_mode(cellcfg_q, i) != CELL_REG)
            arr[1 + NUM_DIN + i] = io_q[i];
   end

   always_comb
   begin
      for (int t = 0; t < NUM_TERMS; t++)
         pt[t] = term_eval(terms_q[t], arr, lit_mask);
      for (int i = 0; i < NUM_CELLS; i++)
      begin
         sum_all[i]   = |pt[i*TERMS_PER_CELL +: TERMS_PER_CELL];
         sum_seven[i] = |pt[i*TERMS_PER_CELL + 1 +: TERMS_PER_CELL - 1];
      end
   end

   // ----------------------------------------------------------------
   // Architecture mode
   // ----------------------------------------------------------------
   // Any register forces registered; otherwise any term OE forces complex
   always_comb
   begin
      arch = ARCH_SIMPLE;
      for (int i = 0; i < NUM_CELLS; i++)
         if (cell_mode(cellcfg_q, i) == CELL_COMB_IO && arch == ARCH_SIMPLE)
            arch = ARCH_COMPLEX;
      for (int i = 0; i < NUM_CELLS; i++)
         if (cell_mode(cellcfg_q, i) == CELL_REG)
            arch = ARCH_REGISTERED;
   end

   // ----------------------------------------------------------------
   // Macrocell output selection
   // ----------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < NUM_CELLS; i++)
      begin
         unique case (cell_mode(cellcfg_q, i))
            CELL_REG:
            begin
               out_d[i] = ~mc_q[i];                      // Cleared flop drives high
               oe_d[i]  = ~oen_q;
            end
            CELL_COMB_IO:
            begin
               out_d[i] = sum_seven[i];
               oe_d[i]  = pt[i*TERMS_PER_CELL + OE_TERM];
            end
            CELL_COMB_OUT:
            begin
               // Simple mode has no term OE, so all eight terms feed the sum
               out_d[i] = (arch == ARCH_SIMPLE) ? sum_all[i] : sum_seven[i];
               oe_d[i]  = 1'b1;
            end
            CELL_INPUT:
            begin
               out_d[i] = 1'b0;
               oe_d[i]  = 1'b0;
            end
         endcase
      end
   end

   // Pin drivers hold their last level and enable while asleep
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         io_out <= '0;
         io_oe  <= '0;
      end
      else if (!asleep)
      begin
         io_out <= out_d;
         io_oe  <= oe_d;
      end
   end

   // ----------------------------------------------------------------
   // Macrocell registers
   // ----------------------------------------------------------------
   // Preload wins over a clock edge in the same cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         mc_q <= '0;
      else if (wr && paddr == ADDR_PRELOAD && !secure_q)
         mc_q <= pwdata[NUM_CELLS-1:0];
      else if (clk_edge)
         for (int i = 0; i < NUM_CELLS; i++)
            if (cell_mode(cellcfg_q, i) == CELL_REG)
               mc_q[i] <= sum_all[i];
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Zero wait states; every access completes in its access cycle
   assign acc    = psel & penable;
   assign wr     = acc & pwrite;
   assign rd     = acc & ~pwrite;
   assign pready = acc;

   always_comb
   begin
      unique case (paddr)
         ADDR_CTRL, ADDR_CELLCFG, ADDR_STATUS, ADDR_TIDX,
         ADDR_TDATA, ADDR_PRELOAD, ADDR_SIG_LO, ADDR_SIG_HI: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      // Verify readback, preload and signature writes are locked by the fuse
      refused = secure_q & ((paddr == ADDR_TDATA) | (paddr == ADDR_PRELOAD) |
                            (wr & (paddr == ADDR_SIG_LO | paddr == ADDR_SIG_HI)));
   end

   assign pslverr = acc & (~hit | refused);

   // Control, configuration and term index
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pd_en_q   <= 1'b0;
         secure_q  <= 1'b0;
         cellcfg_q <= CELLCFG_RESET;
         tidx_q    <= '0;
      end
      else if (wr)
      begin
         if (paddr == ADDR_CTRL)
         begin
            pd_en_q  <= pwdata[CTRL_PD_EN_BIT];
            // Fuse can be set but never cleared short of a reset
            secure_q <= secure_q | pwdata[CTRL_SECURE_BIT];
         end
         if (paddr == ADDR_CELLCFG)
            cellcfg_q <= pwdata[15:0];
         if (paddr == ADDR_TIDX)
            tidx_q <= pwdata[TIDX_W-1:0];
      end
   end

   // Term array and signature
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int t = 0; t < NUM_TERMS; t++)
            terms_q[t] <= '0;                            // All terms off
         sig_q <= {SIG_RESET, SIG_RESET};
      end
      else if (wr && !refused)
      begin
         if (paddr == ADDR_TDATA)
            terms_q[tidx_q] <= term_t'(pwdata);
         if (paddr == ADDR_SIG_LO)
            sig_q[31:0] <= pwdata;
         if (paddr == ADDR_SIG_HI)
            sig_q[63:32] <= pwdata;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb
   begin
      status  = '{secured: secure_q, pr_done: pr_done_q, asleep: asleep, arch: arch};
      rdata_d = '0;
      unique case (paddr)
         ADDR_CTRL:    rdata_d[CTRL_SECURE_BIT:0] = {secure_q, pd_en_q};
         ADDR_CELLCFG: rdata_d[15:0] = cellcfg_q;
         ADDR_STATUS:  rdata_d[$bits(status_t)-1:0] = status;
         ADDR_TIDX:    rdata_d[TIDX_W-1:0] = tidx_q;
         ADDR_TDATA:   rdata_d = secure_q ? 32'h0000_0000 : 32'(terms_q[tidx_q]);
         ADDR_PRELOAD: rdata_d[NUM_CELLS-1:0] = secure_q ? '0 : mc_q;
         ADDR_SIG_LO:  rdata_d = sig_q[31:0];
         ADDR_SIG_HI:  rdata_d = sig_q[63:32];
         default:      rdata_d = '0;
      endcase
   end

   // Read data captured at the end of the setup cycle, stands through access
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prdata <= '0;
      else if (psel && !penable && !pwrite)
         prdata <= rdata_d;
   end

endmodule : pld_ctrl

/* File: shared/pld_ctrl_pkg.sv */
// Package: constants, types and register map of the logic-device control block
// Function
// - Power-up clears all macrocell registers low
// - Sleep pin high enters held state
// - Power-down freezes registers, logic and outputs
// - Tristated outputs stay tristated in power-down
// - Power-down ignores inputs, clock, output enable
// - Keepers stay active during power-down
// - Without power-down option sleep pin is input
// - Programmer may preload each register high/low
// - Security fuse blocks verify and preload
// - 64-bit signature always readable
// - Undriven pins keep last value via keeper
// - Macrocell: registered, comb I/O, comb out, input
// - Exactly one of three architecture modes
// - Unused product terms disabled
// - Registered cell: common OE pin, common clock
// - Comb I/O cell: one OE term, seven sum terms
package pld_ctrl_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int NUM_CELLS      = 8;                    // Macrocells
   localparam int TERMS_PER_CELL = 8;                    // Product terms per macrocell
   localparam int NUM_TERMS      = NUM_CELLS * TERMS_PER_CELL;
   localparam int NUM_DIN        = 7;                    // Dedicated inputs besides the sleep pin
   localparam int ARRAY_W        = 16;                   // Sleep pin + inputs + feedback
   localparam int TIDX_W         = 6;                    // Term index width
   localparam int SLEEP_LIT      = 0;                    // Array column of the sleep pin
   localparam int OE_TERM        = 0;                    // Term used as output enable

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS  = 40000;                // 25 MHz
   localparam int PR_MAX_NS      = 1000;                 // Longest power-up reset interval
   localparam int PR_CYCLES      = (PR_MAX_NS * 1000) / CLK_PERIOD_PS;  // Rounded down

   // ----------------------------------------------------------------
   // APB register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL    = 8'h00;          // Power-down option, fuse
   localparam logic [7:0] ADDR_CELLCFG = 8'h04;          // Two bits per macrocell
   localparam logic [7:0] ADDR_STATUS  = 8'h08;          // Mode, sleep, fuse state
   localparam logic [7:0] ADDR_TIDX    = 8'h0C;          // Term index
   localparam logic [7:0] ADDR_TDATA   = 8'h10;          // Term literal masks
   localparam logic [7:0] ADDR_PRELOAD = 8'h14;          // Register preload / readback
   localparam logic [7:0] ADDR_SIG_LO  = 8'h18;          // Signature bytes 0..3
   localparam logic [7:0] ADDR_SIG_HI  = 8'h1C;          // Signature bytes 4..7

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_PD_EN_BIT  = 0;                   // Power-down option enable
   localparam int CTRL_SECURE_BIT = 1;                   // Security fuse (set only)
   localparam logic [15:0] CELLCFG_RESET = 16'hFFFF;     // All cells dedicated inputs
   localparam logic [31:0] SIG_RESET     = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CELL_REG      = 2'h0,                              // Registered output
      CELL_COMB_IO  = 2'h1,                              // Combinatorial I/O, term OE
      CELL_COMB_OUT = 2'h2,                              // Combinatorial output, always on
      CELL_INPUT    = 2'h3                               // Dedicated input
   } cell_mode_t;

   typedef enum logic [1:0] {ARCH_SIMPLE, ARCH_COMPLEX, ARCH_REGISTERED} arch_t;

   typedef struct packed {
      logic [ARRAY_W-1:0] cmpl;                          // Complement literal mask
      logic [ARRAY_W-1:0] tru;                           // True literal mask
   } term_t;

   typedef struct packed {
      logic        secured;                              // Fuse programmed
      logic        pr_done;                              // Power-up interval over
      logic        asleep;                               // Held state active
      arch_t       arch;                                 // Architecture mode
   } status_t;

endpackage : pld_ctrl_pkg
